// *** hw/ump_pkg.sv ***
package ump_pkg;

	// Line timing: bit period rounded down so the receiver never runs slow
	localparam int CLK_HZ = 20_000_000;
	localparam int BAUD_HZ = 115200;
	localparam int BIT_CYC_I = CLK_HZ / BAUD_HZ;
	localparam logic [8:0] BIT_CYC = 9'(BIT_CYC_I);
	localparam logic [8:0] HALF_CYC = 9'(BIT_CYC_I / 2);
	localparam logic [2:0] LAST_DATA_IDX = 3'h7;

	// Register addresses (bit 8 set selects single-bit space)
	localparam logic [8:0] ADDR_CTRL = 9'h098;
	localparam logic [8:0] ADDR_DATA = 9'h099;
	localparam logic [8:0] ADDR_MODE = 9'h0a9;
	localparam logic [8:0] ADDR_IRQ_STAT = 9'h0f0;
	localparam logic [8:0] ADDR_IRQ_EN = 9'h0f1;
	localparam logic [8:0] ADDR_IRQ_CLR = 9'h0f2;
	localparam logic [8:0] ADDR_CTRL_BITS = 9'h198;

	// Control/status fields
	localparam int B_OVR = 7;
	localparam int B_PERR = 6;
	localparam int B_THRE = 5;
	localparam int B_REN = 4;
	localparam int B_TBX = 3;
	localparam int B_RBX = 2;
	localparam int B_TI = 1;
	localparam int B_RI = 0;

	// Mode register fields and reset value
	localparam int M_MCE = 7;
	localparam int M_PT_HI = 6;
	localparam int M_PT_LO = 5;
	localparam int M_PE = 4;
	localparam int M_XBE = 1;
	localparam logic [7:0] MODE_RST = 8'h0c;

	// Parity types
	localparam logic [1:0] PT_ODD = 2'h0;
	localparam logic [1:0] PT_EVEN = 2'h1;
	localparam logic [1:0] PT_MARK = 2'h2;

	// Interrupt status bits
	localparam int IRQ_W = 4;
	localparam int I_RX = 0;
	localparam int I_TX = 1;
	localparam int I_OVR = 2;
	localparam int I_PERR = 3;

	localparam logic [1:0] FIFO_DEPTH = 2'h3;
	localparam logic [1:0] FIFO_LAST = 2'h2;
	localparam logic [7:0] BROADCAST_ADDR = 8'hff;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_START = 5'h02,
		ST_DATA = 5'h04,
		ST_XBIT = 5'h08,
		ST_STOP = 5'h10
	} ump_state_e;

	// Parity bit for the selected type
	function automatic logic ump_parity(input logic [7:0] d,
		input logic [1:0] pt);
		case (pt)
			PT_ODD: ump_parity = ~^d;
			PT_EVEN: ump_parity = ^d;
			PT_MARK: ump_parity = 1'b1;
			default: ump_parity = 1'b0;
		endcase
	endfunction

endpackage

// *** hw/ump_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ump_link_if;
	logic dev_txd;
	logic node_txd;
	modport dev (output dev_txd, input node_txd);
	modport node (output node_txd, input dev_txd);
endinterface
`default_nettype wire

// *** hw/ump_dev.sv ***
// Summary of operation
// - Address bytes carry extra bit 1, data 0
// - Filter on: receive flag needs extra 1
// - Slave software clears filter on address match
// - Unaddressed slaves keep filter; re-enable after message
// - Shared addresses and role swaps allowed
// - Bit 7 flags byte dropped, FIFO full
// - Bit 6 flags parity error, software clears
// - Bit 5 transmit holding empty, read-only
// - Bit 4 enables receiver; FIFO stays readable
// - Bit 3 sent as extra bit
// - Bit 2 received extra or stop bit
// - Bit 1 set at transmit stop bit
// - Bit 0 set at receive stop sample
// - Receive flag holds while FIFO has more than one byte
// - Control at 0x98, bit addressable
// - Extra bit only if enabled, no parity
// - Three-entry FIFO, overflow drops and flags
// - Filter enable is mode bit 7
`timescale 1ns/1ps
`default_nettype none
module ump_dev
	import ump_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	ump_link_if.dev link,
	input wire logic [8:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic irq
);
	logic ovr_ff, perr_ff, ren_ff, tbx_ff, ti_ff, ri_ff;
	logic [7:0] mode_ff;
	logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff;
	logic irq_ff;
	logic [7:0] rdata_ff;
	logic [7:0] ctrl_rd, wmask, wval;
	logic has_x, xbe_only, pe;
	logic [1:0] pt;
	logic [IRQ_W-1:0] nxt_stat, clr, ev;

	// Transmit state
	ump_state_e tx_st_ff;
	logic [8:0] tx_cnt_ff;
	logic [2:0] tx_idx_ff;
	logic [7:0] tx_sh_ff;
	logic tx_xb_ff, tx_hx_ff, txd_ff, ti_set;

	// Receive state
	ump_state_e rx_st_ff;
	logic [8:0] rx_cnt_ff;
	logic [2:0] rx_idx_ff;
	logic [7:0] rx_sh_ff;
	logic rx_xb_ff, rx_s1_ff, rx_s2_ff, rx_prev_ff;
	logic rx_end, rx_xval, rx_perr, rx_ok, push, pop, ovr_set, perr_set;

	// Receive FIFO, head is the data buffer
	logic [7:0] fifo_d [0:2];
	logic fifo_x [0:2];
	logic fifo_p [0:2];
	logic [1:0] wp_ff, rp_ff, cnt_ff, rp_nxt;

	assign pe = mode_ff[M_PE];
	assign pt = mode_ff[M_PT_HI:M_PT_LO];
	assign xbe_only = mode_ff[M_XBE] & ~pe;
	assign has_x = mode_ff[M_XBE] | pe;

	// Byte write or single-bit write into control register
	always_comb
	begin
		wmask = 8'h00;
		wval = wdata;
		if (wr && addr == ADDR_CTRL)
			wmask = 8'hff;
		else if (wr && addr[8:3] == ADDR_CTRL_BITS[8:3])
		begin
			wmask = 8'h01 << addr[2:0];
			wval = {8{wdata[0]}};
		end
	end

	// Control flags; hardware set wins over software clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ovr_ff <= 1'b0;
			perr_ff <= 1'b0;
			ren_ff <= 1'b0;
			tbx_ff <= 1'b0;
			ti_ff <= 1'b0;
		end
		else
		begin
			ovr_ff <= ovr_set | (wmask[B_OVR] ? wval[B_OVR] : ovr_ff);
			perr_ff <= perr_set | (wmask[B_PERR] ? wval[B_PERR] : perr_ff);
			ren_ff <= wmask[B_REN] ? wval[B_REN] : ren_ff;
			tbx_ff <= wmask[B_TBX] ? wval[B_TBX] : tbx_ff;
			ti_ff <= ti_set | (wmask[B_TI] ? wval[B_TI] : ti_ff);
		end
	end

	// Receive flag: clear ignored until only the buffered byte remains
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ri_ff <= 1'b0;
		else if (push)
			ri_ff <= 1'b1;
		else if (wmask[B_RI] && (wval[B_RI] || cnt_ff <= 2'h1))
			ri_ff <= wval[B_RI];
	end

	// Mode and interrupt registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_ff <= MODE_RST;
			irq_en_ff <= '0;
		end
		else if (wr && addr == ADDR_MODE)
			mode_ff <= wdata;
		else if (wr && addr == ADDR_IRQ_EN)
			irq_en_ff <= wdata[IRQ_W-1:0];
	end

	// Sticky events; one level output from enabled bits
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_stat_ff <= '0;
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_stat_ff <= nxt_stat;
			irq_ff <= |(nxt_stat & irq_en_ff);
		end
	end
	assign clr = (wr && addr == ADDR_IRQ_CLR) ? wdata[IRQ_W-1:0] : '0;
	assign ev = {perr_set, ovr_set, ti_set, push};
	assign nxt_stat = (irq_stat_ff & ~clr) | ev;

	assign ctrl_rd = {ovr_ff, perr_ff, tx_st_ff == ST_IDLE, ren_ff, tbx_ff,
		(cnt_ff != 2'h0) & fifo_x[rp_ff], ti_ff, ri_ff};

	// Read data one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= 8'h00;
		else if (rd)
		begin
			case (addr)
				ADDR_CTRL: rdata_ff <= ctrl_rd;
				ADDR_DATA: rdata_ff <= (cnt_ff != 2'h0) ? fifo_d[rp_ff] : 8'h00;
				ADDR_MODE: rdata_ff <= mode_ff;
				ADDR_IRQ_STAT: rdata_ff <= {4'h0, irq_stat_ff};
				ADDR_IRQ_EN: rdata_ff <= {4'h0, irq_en_ff};
				default: rdata_ff <= 8'h00;
			endcase
		end
	end
	assign rdata = rdata_ff;
	assign irq = irq_ff;
	assign link.dev_txd = txd_ff;

	// Transmitter; a write while busy is dropped, not queued
	assign ti_set = (tx_cnt_ff == 9'h000) &&
		((tx_st_ff == ST_DATA && tx_idx_ff == LAST_DATA_IDX && !tx_hx_ff) ||
		tx_st_ff == ST_XBIT);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_st_ff <= ST_IDLE;
			tx_cnt_ff <= 9'h000;
			tx_idx_ff <= 3'h0;
			tx_sh_ff <= 8'h00;
			tx_xb_ff <= 1'b0;
			tx_hx_ff <= 1'b0;
			txd_ff <= 1'b1;
		end
		else if (tx_st_ff == ST_IDLE)
		begin
			if (wr && addr == ADDR_DATA)
			begin
				tx_st_ff <= ST_START;
				tx_cnt_ff <= BIT_CYC - 9'h001;
				tx_sh_ff <= wdata;
				tx_hx_ff <= has_x;
				tx_xb_ff <= pe ? ump_parity(wdata, pt) : tbx_ff;
				txd_ff <= 1'b0;
			end
		end
		else if (tx_cnt_ff != 9'h000)
			tx_cnt_ff <= tx_cnt_ff - 9'h001;
		else
		begin
			tx_cnt_ff <= BIT_CYC - 9'h001;
			case (tx_st_ff)
				ST_START:
				begin
					tx_st_ff <= ST_DATA;
					tx_idx_ff <= 3'h0;
					txd_ff <= tx_sh_ff[0];
				end
				ST_DATA:
				begin
					tx_idx_ff <= tx_idx_ff + 3'h1;
					tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
					if (tx_idx_ff != LAST_DATA_IDX)
						txd_ff <= tx_sh_ff[1];
					else if (tx_hx_ff)
					begin
						tx_st_ff <= ST_XBIT;
						txd_ff <= tx_xb_ff;
					end
					else
					begin
						tx_st_ff <= ST_STOP;
						txd_ff <= 1'b1;
					end
				end
				ST_XBIT:
				begin
					tx_st_ff <= ST_STOP;
					txd_ff <= 1'b1;
				end
				default:
				begin
					tx_st_ff <= ST_IDLE;
					txd_ff <= 1'b1;
				end
			endcase
		end
	end

	// Line synchroniser; receiver looks at the second stage and its delayed copy
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
		end
		else
		begin
			rx_s1_ff <= link.node_txd;
			rx_s2_ff <= rx_s1_ff;
			rx_prev_ff <= rx_s2_ff;
		end
	end

	// Receiver samples each bit at its middle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_st_ff <= ST_IDLE;
			rx_cnt_ff <= 9'h000;
			rx_idx_ff <= 3'h0;
			rx_sh_ff <= 8'h00;
			rx_xb_ff <= 1'b0;
		end
		else if (rx_st_ff == ST_IDLE)
		begin
			if (ren_ff && rx_prev_ff && !rx_s2_ff)
			begin
				rx_st_ff <= ST_START;
				rx_cnt_ff <= HALF_CYC - 9'h001;
			end
		end
		else if (rx_cnt_ff != 9'h000)
			rx_cnt_ff <= rx_cnt_ff - 9'h001;
		else
		begin
			rx_cnt_ff <= BIT_CYC - 9'h001;
			case (rx_st_ff)
				ST_START:
				begin
					rx_st_ff <= rx_s2_ff ? ST_IDLE : ST_DATA;
					rx_idx_ff <= 3'h0;
				end
				ST_DATA:
				begin
					rx_sh_ff <= {rx_s2_ff, rx_sh_ff[7:1]};
					rx_idx_ff <= rx_idx_ff + 3'h1;
					if (rx_idx_ff == LAST_DATA_IDX)
						rx_st_ff <= has_x ? ST_XBIT : ST_STOP;
				end
				ST_XBIT:
				begin
					rx_xb_ff <= rx_s2_ff;
					rx_st_ff <= ST_STOP;
				end
				default: rx_st_ff <= ST_IDLE;
			endcase
		end
	end

	// Stop sample decides whether the byte is kept
	assign rx_end = rx_st_ff == ST_STOP && rx_cnt_ff == 9'h000;
	assign rx_xval = xbe_only ? rx_xb_ff : rx_s2_ff;
	assign rx_perr = pe & (rx_xb_ff != ump_parity(rx_sh_ff, pt));
	assign rx_ok = rx_end & rx_s2_ff &
		(~mode_ff[M_MCE] | rx_xval);
	assign pop = rd && addr == ADDR_DATA && cnt_ff != 2'h0;
	assign push = rx_ok && (cnt_ff != FIFO_DEPTH || pop);
	assign ovr_set = rx_ok && cnt_ff == FIFO_DEPTH && !pop;
	assign rp_nxt = (rp_ff == FIFO_LAST) ? 2'h0 : rp_ff + 2'h1;
	// Flag parity when an erroneous byte becomes the oldest
	assign perr_set = pe & ((push & rx_perr &
		(cnt_ff == 2'h0 || (pop && cnt_ff == 2'h1))) |
		(pop & (cnt_ff >= 2'h2) & fifo_p[rp_nxt]));

	// FIFO pointers and count
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_ff <= 2'h0;
			rp_ff <= 2'h0;
			cnt_ff <= 2'h0;
		end
		else
		begin
			if (push)
				wp_ff <= (wp_ff == FIFO_LAST) ? 2'h0 : wp_ff + 2'h1;
			if (pop)
				rp_ff <= rp_nxt;
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end

	// FIFO storage, no reset needed
	always_ff @(posedge clk)
	begin
		if (push)
		begin
			fifo_d[wp_ff] <= rx_sh_ff;
			fifo_x[wp_ff] <= rx_xval;
			fifo_p[wp_ff] <= rx_perr;
		end
	end

endmodule
`default_nettype wire

// *** hw/ump_node.sv ***
`timescale 1ns/1ps
`default_nettype none
module ump_node
	import ump_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	ump_link_if.node link,
	input wire logic [7:0] own_addr,
	input wire logic send_valid,
	input wire logic [7:0] send_data,
	input wire logic send_is_addr,
	output logic send_ready,
	output logic recv_valid,
	output logic [7:0] recv_data,
	output logic recv_is_addr,
	output logic addressed
);
	ump_state_e tx_st_ff, rx_st_ff;
	logic [8:0] tx_cnt_ff, rx_cnt_ff;
	logic [3:0] tx_left_ff;
	logic [8:0] tx_sh_ff;
	logic txd_ff, rdy_ff;
	logic [2:0] rx_idx_ff;
	logic [8:0] rx_sh_ff;
	logic s1_ff, s2_ff, prev_ff;
	logic rv_ff, ria_ff, sel_ff;
	logic [7:0] rd_ff;

	assign link.node_txd = txd_ff;
	assign send_ready = rdy_ff;
	assign recv_valid = rv_ff;
	assign recv_data = rd_ff;
	assign recv_is_addr = ria_ff;
	assign addressed = sel_ff;

	// Frame: start, 8 data, extra bit, stop; shifted LSB first
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_st_ff <= ST_IDLE;
			tx_cnt_ff <= 9'h000;
			tx_left_ff <= 4'h0;
			tx_sh_ff <= 9'h000;
			txd_ff <= 1'b1;
			rdy_ff <= 1'b1;
		end
		else if (tx_st_ff == ST_IDLE)
		begin
			if (send_valid && rdy_ff)
			begin
				tx_st_ff <= ST_DATA;
				tx_cnt_ff <= BIT_CYC - 9'h001;
				tx_sh_ff <= {send_is_addr, send_data};
				tx_left_ff <= 4'h9;
				txd_ff <= 1'b0;
				rdy_ff <= 1'b0;
			end
		end
		else if (tx_cnt_ff != 9'h000)
			tx_cnt_ff <= tx_cnt_ff - 9'h001;
		else
		begin
			tx_cnt_ff <= BIT_CYC - 9'h001;
			case (tx_st_ff)
				ST_DATA:
				begin
					txd_ff <= tx_sh_ff[0];
					tx_sh_ff <= {1'b0, tx_sh_ff[8:1]};
					tx_left_ff <= tx_left_ff - 4'h1;
					if (tx_left_ff == 4'h1)
						tx_st_ff <= ST_XBIT;
				end
				ST_XBIT:
				begin
					txd_ff <= 1'b1;
					tx_st_ff <= ST_STOP;
				end
				default:
				begin
					tx_st_ff <= ST_IDLE;
					rdy_ff <= 1'b1;
				end
			endcase
		end
	end

	// Line synchroniser
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			prev_ff <= 1'b1;
		end
		else
		begin
			s1_ff <= link.dev_txd;
			s2_ff <= s1_ff;
			prev_ff <= s2_ff;
		end
	end

	// Receiver with hardware address filter in place of slave software
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_st_ff <= ST_IDLE;
			rx_cnt_ff <= 9'h000;
			rx_idx_ff <= 3'h0;
			rx_sh_ff <= 9'h000;
			rv_ff <= 1'b0;
			ria_ff <= 1'b0;
			rd_ff <= 8'h00;
			sel_ff <= 1'b0;
		end
		else
		begin
			rv_ff <= 1'b0;
			if (rx_st_ff == ST_IDLE)
			begin
				if (prev_ff && !s2_ff)
				begin
					rx_st_ff <= ST_START;
					rx_cnt_ff <= HALF_CYC - 9'h001;
				end
			end
			else if (rx_cnt_ff != 9'h000)
				rx_cnt_ff <= rx_cnt_ff - 9'h001;
			else
			begin
				rx_cnt_ff <= BIT_CYC - 9'h001;
				case (rx_st_ff)
					ST_START:
					begin
						rx_st_ff <= s2_ff ? ST_IDLE : ST_DATA;
						rx_idx_ff <= 3'h0;
					end
					ST_DATA:
					begin
						rx_sh_ff <= {s2_ff, rx_sh_ff[8:1]};
						rx_idx_ff <= rx_idx_ff + 3'h1;
						if (rx_idx_ff == LAST_DATA_IDX)
							rx_st_ff <= ST_XBIT;
					end
					ST_XBIT:
					begin
						rx_sh_ff <= {s2_ff, rx_sh_ff[8:1]};
						rx_st_ff <= ST_STOP;
					end
					default:
					begin
						rx_st_ff <= ST_IDLE;
						if (s2_ff && rx_sh_ff[8])
						begin
							// Own or broadcast address selects this node
							sel_ff <= rx_sh_ff[7:0] == own_addr ||
								rx_sh_ff[7:0] == BROADCAST_ADDR;
							rv_ff <= 1'b1;
							ria_ff <= 1'b1;
							rd_ff <= rx_sh_ff[7:0];
						end
						else if (s2_ff && sel_ff)
						begin
							rv_ff <= 1'b1;
							ria_ff <= 1'b0;
							rd_ff <= rx_sh_ff[7:0];
						end
					end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// *** testbench/ump_link_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module ump_link_chk
	import ump_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic dev_txd,
	input wire logic node_txd
);
	logic [1:0] busy_ff;
	logic [1:0] txd_ff;
	logic [1:0][8:0] cnt_ff;
	logic [1:0][3:0] bit_ff;
	logic [1:0] txd;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	assign txd = {node_txd, dev_txd};

	// Frame tracker per line; a high extra bit may end a frame early,
	// which is harmless since the stop bit after it never moves
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_ff <= 2'h0;
			txd_ff <= 2'h3;
			cnt_ff <= '0;
			bit_ff <= '0;
		end
		else
		begin
			txd_ff <= txd;
			for (int i = 0; i < 2; i++)
			begin
				if (!busy_ff[i])
				begin
					busy_ff[i] <= txd_ff[i] && !txd[i];
					cnt_ff[i] <= 9'h001;
					bit_ff[i] <= 4'h0;
				end
				else if (cnt_ff[i] == BIT_CYC - 9'h001)
				begin
					busy_ff[i] <= !(txd[i] && bit_ff[i] >= 4'h9);
					cnt_ff[i] <= 9'h000;
					bit_ff[i] <= bit_ff[i] + 4'h1;
				end
				else
					cnt_ff[i] <= cnt_ff[i] + 9'h001;
			end
		end
	end

	a_idle_after_reset: assert property (
		$rose(rst_n) |-> dev_txd && node_txd)
		else $error("line not idle after reset");
	a_dev_bit_hold: assert property (
		busy_ff[0] && cnt_ff[0] != 9'h000 |-> $stable(dev_txd))
		else $error("device line moved inside a bit");
	a_node_bit_hold: assert property (
		busy_ff[1] && cnt_ff[1] != 9'h000 |-> $stable(node_txd))
		else $error("node line moved inside a bit");
	a_dev_stop_high: assert property (
		busy_ff[0] && bit_ff[0] == 4'ha |-> dev_txd)
		else $error("device stop bit low");
	a_node_stop_high: assert property (
		busy_ff[1] && bit_ff[1] == 4'ha |-> node_txd)
		else $error("node stop bit low");
	a_dev_frame_len: assert property (
		busy_ff[0] |-> bit_ff[0] <= 4'ha)
		else $error("device frame too long");
	a_node_frame_len: assert property (
		busy_ff[1] |-> bit_ff[1] <= 4'ha)
		else $error("node frame too long");
	a_dev_start_mid: assert property (
		$fell(dev_txd) && !busy_ff[0] |-> ##86 !dev_txd)
		else $error("device start bit too short");

	c_dev_frame: cover property ($fell(dev_txd) && !busy_ff[0]);
	c_node_frame: cover property ($fell(node_txd) && !busy_ff[1]);
	c_dev_extra: cover property (busy_ff[0] && bit_ff[0] == 4'ha);
endmodule
`default_nettype wire

// *** testbench/uart_multiproc_ctrl_status_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_multiproc_ctrl_status_bench
	import ump_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [8:0] addr = 9'h000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] own_addr = 8'h00;
	logic send_valid = 1'b0;
	logic [7:0] send_data = 8'h00;
	logic send_is_addr = 1'b0;
	logic [7:0] rdata, recv_data, rv, d;
	logic [7:0] q [4];
	logic irq, send_ready, recv_valid, recv_is_addr, addressed, got;
	logic sel_m;
	int fail_count = 0;
	int check_count = 0;
	int seed = 32'h1760;

	ump_link_if link();
	ump_dev i_ump_dev (.clk(clk), .rst_n(rst_n), .link(link.dev),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.irq(irq));
	ump_node i_ump_node (.clk(clk), .rst_n(rst_n), .link(link.node),
		.own_addr(own_addr), .send_valid(send_valid),
		.send_data(send_data), .send_is_addr(send_is_addr),
		.send_ready(send_ready), .recv_valid(recv_valid),
		.recv_data(recv_data), .recv_is_addr(recv_is_addr),
		.addressed(addressed));
	ump_link_chk i_ump_link_chk (.clk(clk), .rst_n(rst_n),
		.dev_txd(link.dev_txd), .node_txd(link.node_txd));

	// Free-running system clock
	initial
		forever #25 clk = ~clk;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// Node address match, own or broadcast
	function automatic logic addr_hit(input logic [7:0] v);
		return v == own_addr || v == BROADCAST_ADDR;
	endfunction

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic timeout();
		fail_count++;
		$display("mismatch at %0t: wait ran out", $time);
		give_verdict();
	endtask

	task automatic wr_reg(input logic [8:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data is registered at the strobe edge and holds until the next read
	task automatic rd_reg(input logic [8:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic set_bit(input int n, input logic v);
		wr_reg(ADDR_CTRL_BITS + 9'(n), {7'h00, v});
	endtask

	// Pulse is one cycle wide, so look just after every edge
	task automatic wait_recv(output logic g);
		g = 1'b0;
		for (int i = 0; i < 2500 && !g; i++)
		begin
			@(posedge clk);
			#1;
			g = (recv_valid === 1'b1);
		end
	endtask

	task automatic wait_thre();
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 1500 && s[B_THRE] !== 1'b1; i++)
			rd_reg(ADDR_CTRL, s);
		if (s[B_THRE] !== 1'b1)
			timeout();
	endtask

	// Never writes data while the holding register is busy
	task automatic dev_send(input logic [7:0] v, output logic g);
		logic [7:0] s;
		wr_reg(ADDR_DATA, v);
		rd_reg(ADDR_CTRL, s);
		check({7'h00, s[B_THRE]}, 8'h00);
		wait_recv(g);
		wait_thre();
	endtask

	task automatic node_send(input logic [7:0] v, input logic a);
		@(posedge clk);
		send_data <= v;
		send_is_addr <= a;
		send_valid <= 1'b1;
		@(posedge clk);
		send_valid <= 1'b0;
		// Ready is a flop output; look once it has settled
		repeat (2) @(posedge clk);
		#1;
		for (int i = 0; i < 2500 && send_ready !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		if (send_ready !== 1'b1)
			timeout();
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		own_addr <= {1'b0, 7'($random(seed))};
		rst_n <= 1'b1;
		rd_reg(ADDR_CTRL, rv);
		check(rv, 8'h20);
		rd_reg(ADDR_MODE, rv);
		check(rv, MODE_RST);
		rd_reg(9'h0a0, rv);
		check(rv, 8'h00);
		$display("test reset done");
		// Address frame selects the node, then data follows
		wr_reg(ADDR_MODE, 8'h0e);
		wr_reg(ADDR_IRQ_EN, 8'h02);
		set_bit(B_TBX, 1'b1);
		dev_send(own_addr, got);
		check({6'h00, got, recv_is_addr}, 8'h03);
		check({7'h00, addressed}, 8'h01);
		rd_reg(ADDR_CTRL, rv);
		check(rv, 8'h2a);
		check({7'h00, irq}, 8'h01);
		wr_reg(ADDR_IRQ_CLR, 8'h02);
		set_bit(B_TI, 1'b0);
		rd_reg(ADDR_CTRL, rv);
		check(rv, 8'h28);
		check({7'h00, irq}, 8'h00);
		wr_reg(ADDR_IRQ_EN, 8'h00);
		set_bit(B_TBX, 1'b0);
		for (int k = 0; k < 3; k++)
		begin
			d = 8'($random(seed));
			dev_send(d, got);
			check({got, recv_is_addr, 6'h00}, 8'h80);
			check(recv_data, d);
		end
		check({7'h00, irq}, 8'h00);
		rd_reg(ADDR_IRQ_STAT, rv);
		check(rv & 8'h02, 8'h02);
		// Foreign address deafens the node, broadcast wakes it
		set_bit(B_TBX, 1'b1);
		dev_send(own_addr ^ 8'h01, got);
		check({got, addressed, 6'h00}, 8'h80);
		set_bit(B_TBX, 1'b0);
		dev_send(8'h5a, got);
		check({7'h00, got}, 8'h00);
		set_bit(B_TBX, 1'b1);
		dev_send(BROADCAST_ADDR, got);
		check({got, addressed, 6'h00}, 8'hc0);
		// Even parity takes the ninth slot; the set extra bit must not leak
		// A parity of 1 looks like an address to the node and may deafen it
		wr_reg(ADDR_MODE, 8'h3e);
		sel_m = 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			d = 8'($random(seed));
			dev_send(d, got);
			check({got, got & recv_is_addr, 6'h00},
				{^d | sel_m, ^d, 6'h00});
			if (^d)
				sel_m = addr_hit(d);
			check({7'h00, addressed}, {7'h00, sel_m});
		end
		$display("test transmit done");
		// Receive with the address filter on
		wr_reg(ADDR_MODE, 8'h8e);
		wr_reg(ADDR_IRQ_EN, 8'h01);
		set_bit(B_TI, 1'b0);
		set_bit(B_REN, 1'b1);
		node_send(8'h33, 1'b0);
		rd_reg(ADDR_CTRL, rv);
		check(rv, 8'h38);
		check({7'h00, irq}, 8'h00);
		d = 8'($random(seed));
		node_send(d, 1'b1);
		rd_reg(ADDR_CTRL, rv);
		check(rv, 8'h3d);
		check({7'h00, irq}, 8'h01);
		rd_reg(ADDR_DATA, rv);
		check(rv, d);
		set_bit(B_RI, 1'b0);
		wr_reg(ADDR_IRQ_CLR, 8'h01);
		rd_reg(ADDR_CTRL, rv);
		check(rv, 8'h38);
		check({7'h00, irq}, 8'h00);
		// Four bytes into three places; clear refused while data waits
		wr_reg(ADDR_MODE, 8'h0e);
		for (int k = 0; k < 4; k++)
		begin
			q[k] = 8'($random(seed));
			node_send(q[k], 1'b0);
		end
		set_bit(B_RI, 1'b0);
		set_bit(B_REN, 1'b0);
		rd_reg(ADDR_CTRL, rv);
		check(rv, 8'ha9);
		for (int k = 0; k < 3; k++)
		begin
			rd_reg(ADDR_DATA, rv);
			check(rv, q[k]);
		end
		set_bit(B_RI, 1'b0);
		node_send(8'hc3, 1'b0);
		rd_reg(ADDR_CTRL, rv);
		check(rv & 8'h01, 8'h00);
		// Wrong parity bit on a received byte
		wr_reg(ADDR_MODE, 8'h3e);
		set_bit(B_OVR, 1'b0);
		set_bit(B_REN, 1'b1);
		d = 8'($random(seed));
		node_send(d, ~^d);
		rd_reg(ADDR_CTRL, rv);
		check(rv & 8'hc1, 8'h41);
		rd_reg(ADDR_DATA, rv);
		check(rv, d);
		rd_reg(ADDR_CTRL, rv);
		check(rv & 8'h40, 8'h40);
		set_bit(B_PERR, 1'b0);
		rd_reg(ADDR_CTRL, rv);
		check(rv & 8'h40, 8'h00);
		$display("test receive done");
		give_verdict();
	end
endmodule
`default_nettype wire
